//--- tdr_top.sv
// tdr_top.sv: tamper detection, clock monitor and penalty logic with wishbone slave
// assumes: clk_i is the always-running configuration oscillator; user_clk_i and
// pins are asynchronous; measurements come from logic on clk_i
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "tdr_defs.svh"

// Summary of operation
// - enabled alarm raises interrupt toward processor
// - upper/lower limits per parameter flag alarms
// - reference choice from pin shown in status
// - over-temperature shuts down; rail alarm penalizes
// - clock monitor referenced to config oscillator
// - user clock outside bounds asserts penalty
// - all logic clocked by internal oscillator
// - reprogram clears config, flops, key expansion
// - reprogram equals program pin, wipes RAMs
// - fuse key plus encrypted-only refuses plain
// - key wipe write, verify bit shows cleared
// - key wipe penalty prevents decrypting old image
// - new key stored, CRC checked, POR before load
// - only battery key replaceable, fuse key fixed
// - key wipe combinable with reprogram penalty
// - response selects set-only, cleared by reset
module tdr_top #(
   parameter int MEAS_W        = 10,    // measurement width
   parameter int CNT_W         = 16,    // edge counter width
   parameter int WINDOW_CYCLES = 1024,  // reference cycles per window
   parameter int KEY_WORDS     = 8      // battery key words
) (
   input  wire logic              clk_i,              // config oscillator clock
   input  wire logic              rst_i,              // power-on reset
   input  wire logic              wb_cyc_i,           // bus cycle
   input  wire logic              wb_stb_i,           // bus strobe
   input  wire logic              wb_we_i,            // write enable
   input  wire logic [7:0]        wb_adr_i,           // byte address
   input  wire logic [3:0]        wb_sel_i,           // byte lanes
   input  wire logic [31:0]       wb_dat_i,           // write data
   output logic      [31:0]       wb_dat_o,           // read data
   output logic                   wb_ack_o,           // acknowledge
   input  wire logic [MEAS_W-1:0] temp_meas_i,        // temperature sample
   input  wire logic [MEAS_W-1:0] vrail_meas_i,       // supply rail sample
   input  wire logic              user_clk_i,         // monitored user clock
   input  wire logic              vref_int_sel_i,     // reference select pin
   input  wire logic              fuse_key_sel_i,     // key source is fuse
   input  wire logic              enc_only_fuse_i,    // encrypted-only fuse
   input  wire logic              load_req_i,         // image load request pulse
   input  wire logic              load_encrypted_i,   // image is encrypted
   output logic                   alarm_irq_o,        // alarm interrupt
   output logic                   shutdown_o,         // system shutdown
   output logic                   reprogram_o,        // clear config, flops, rams
   output logic                   key_wipe_o,         // key store zeroize strobe
   output logic                   load_accept_o,      // image load accepted pulse
   output logic                   load_refuse_o       // image load refused pulse
);

   // ------------------------------------------------------------------
   // constants and helpers
   // ------------------------------------------------------------------
   localparam int WIN_W = $clog2(WINDOW_CYCLES + 1);

   // crc-32 update over one word
   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] data);
      logic [31:0] c;
      c = crc;
      for (int i = 31; i >= 0; i--)
      begin
         c = {c[30:0], 1'b0} ^ ((c[31] ^ data[i]) ? `TDR_CRC_POLY : 32'h00000000);
      end
      return c;
   endfunction : crc_step

   // band check on a measurement
   function automatic logic out_of_band(input logic [MEAS_W-1:0] v, input logic [31:0] lim);
      return (v > lim[16 +: MEAS_W]) || (v < lim[MEAS_W-1:0]);
   endfunction : out_of_band

   // byte-lane merge for writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] uclk_sync_reg;   // user clock: two sync stages plus edge history
   logic [1:0] vref_sync_reg;   // reference select pin
   logic [1:0] fsel_sync_reg;   // fuse key select
   logic [1:0] enco_sync_reg;   // encrypted-only fuse

   // sync chains, no logic on first stage
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         uclk_sync_reg <= 3'h0;
         vref_sync_reg <= 2'h0;
         fsel_sync_reg <= 2'h0;
         enco_sync_reg <= 2'h0;
      end
      else
      begin
         uclk_sync_reg <= {uclk_sync_reg[1:0], user_clk_i};
         vref_sync_reg <= {vref_sync_reg[0], vref_int_sel_i};
         fsel_sync_reg <= {fsel_sync_reg[0], fuse_key_sel_i};
         enco_sync_reg <= {enco_sync_reg[0], enc_only_fuse_i};
      end
   end

   logic uclk_rise;   // rising edge of synchronised user clock
   assign uclk_rise = uclk_sync_reg[1] & ~uclk_sync_reg[2];

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [3:0]        ctrl_reg,      ctrl_next;       // enables
   logic [31:0]       temp_lim_reg,  temp_lim_next;   // temperature band
   logic [31:0]       vrail_lim_reg, vrail_lim_next;  // rail band
   logic [31:0]       clk_lim_reg,   clk_lim_next;    // max:min edge counts
   logic [`TDR_RSP_W-1:0] rsp_reg,   rsp_next;        // set-only responses
   logic [31:0]       crc_exp_reg,   crc_exp_next;    // expected key crc
   logic [31:0]       crc_run_reg,   crc_run_next;    // running crc of staged key
   logic [31:0]       stage_reg [KEY_WORDS];          // staged new key
   logic [31:0]       stage_next [KEY_WORDS];
   logic [31:0]       key_reg [KEY_WORDS];            // battery-backed key store
   logic [31:0]       key_next [KEY_WORDS];
   logic [9:0]        status_reg,    status_next;     // status flags
   logic [WIN_W-1:0]  win_reg,       win_next;        // window timer
   logic [CNT_W-1:0]  edge_reg,      edge_next;       // edges in window
   logic [CNT_W-1:0]  last_cnt_reg,  last_cnt_next;   // last window count
   logic [7:0]        wipe_cnt_reg,  wipe_cnt_next;   // reprogram hold
   tdr_pkg::tdr_seq_type seq_reg,    seq_next;        // penalty sequencer
   logic [31:0]       dat_reg,       dat_next;        // bus read data
   logic              ack_reg,       ack_next;        // bus ack
   logic              irq_reg, irq_next, shut_reg, shut_next;
   logic              reprog_reg, reprog_next, wipe_reg, wipe_next;
   logic              lacc_reg, lacc_next, lref_reg, lref_next;

   // ------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------
   always_comb
   begin
      logic        req;      // bus request this cycle
      logic        wr;       // write takes effect this edge
      logic [7:0]  a;        // word-aligned address
      logic        temp_al;  // temperature out of band
      logic        vrail_al; // rail out of band
      logic        clk_bad;  // window verdict failed
      logic [CNT_W-1:0] cnt_now; // edges in window, this cycle included
      logic        tamper;   // any penalty-class event
      logic        do_rep;   // reprogram this cycle
      logic        do_wipe;  // key wipe this cycle
      logic        key_zero; // key store all zero
      logic [31:0] rd;       // read mux
      req      = wb_cyc_i & wb_stb_i;
      wr       = req & wb_we_i & ack_reg;
      a        = {wb_adr_i[7:2], 2'b00};
      ctrl_next      = ctrl_reg;
      temp_lim_next  = temp_lim_reg;
      vrail_lim_next = vrail_lim_reg;
      clk_lim_next   = clk_lim_reg;
      rsp_next       = rsp_reg;
      crc_exp_next   = crc_exp_reg;
      crc_run_next   = crc_run_reg;
      stage_next     = stage_reg;
      key_next       = key_reg;
      status_next    = status_reg;
      last_cnt_next  = last_cnt_reg;
      seq_next       = seq_reg;
      wipe_cnt_next  = wipe_cnt_reg;
      do_rep         = 1'b0;
      do_wipe        = 1'b0;
      // alarms against programmed bands
      temp_al  = ctrl_reg[`TDR_CTRL_TEMP_EN]  & out_of_band(temp_meas_i, temp_lim_reg);
      vrail_al = ctrl_reg[`TDR_CTRL_VRAIL_EN] & out_of_band(vrail_meas_i, vrail_lim_reg);
      // clock window on the oscillator clock
      clk_bad   = 1'b0;
      win_next  = win_reg + WIN_W'(1);
      cnt_now   = edge_reg + (uclk_rise && edge_reg != {CNT_W{1'b1}} ? CNT_W'(1) : CNT_W'(0));
      edge_next = cnt_now;
      if (win_reg == WIN_W'(WINDOW_CYCLES - 1))
      begin
         win_next      = '0;
         edge_next     = '0;
         // verdict on the full count, kept apart from the restarted counter
         last_cnt_next = cnt_now;
         clk_bad       = ctrl_reg[`TDR_CTRL_CLKMON_EN] &&
                         (cnt_now < clk_lim_reg[CNT_W-1:0] ||
                          cnt_now > clk_lim_reg[16 +: CNT_W]);
      end
      tamper = vrail_al | clk_bad;
      // sticky alarm status, cleared only by reset; reference bit follows the pin
      status_next[`TDR_ST_TEMP_ALARM]  = status_reg[`TDR_ST_TEMP_ALARM] | temp_al;
      status_next[`TDR_ST_VRAIL_ALARM] = status_reg[`TDR_ST_VRAIL_ALARM] | vrail_al;
      status_next[`TDR_ST_CLK_FAULT]   = status_reg[`TDR_ST_CLK_FAULT] | clk_bad;
      status_next[`TDR_ST_VREF_INT]    = vref_sync_reg[1];
      // register writes, taken at the ack edge
      if (wr)
      begin
         case (a)
            `TDR_OFF_CTRL:      ctrl_next      = wb_sel_i[0] ? wb_dat_i[3:0] : ctrl_reg;
            `TDR_OFF_TEMP_LIM:  temp_lim_next  = lane_merge(temp_lim_reg, wb_dat_i, wb_sel_i);
            `TDR_OFF_VRAIL_LIM: vrail_lim_next = lane_merge(vrail_lim_reg, wb_dat_i, wb_sel_i);
            `TDR_OFF_CLK_LIM:   clk_lim_next   = lane_merge(clk_lim_reg, wb_dat_i, wb_sel_i);
            // only ones are accepted; zeros cannot clear a selection
            `TDR_OFF_RESPONSE:  rsp_next = rsp_reg | (wb_sel_i[0] ? wb_dat_i[`TDR_RSP_W-1:0]
                                                                   : '0);
            `TDR_OFF_KEY_CRC:   crc_exp_next   = lane_merge(crc_exp_reg, wb_dat_i, wb_sel_i);
            `TDR_OFF_COMMAND:
            begin
               do_rep  = wb_sel_i[0] & wb_dat_i[`TDR_CMD_REPROG];
               do_wipe = wb_sel_i[0] & wb_dat_i[`TDR_CMD_KEY_WIPE];
               if (wb_sel_i[0] && wb_dat_i[`TDR_CMD_KEY_COMMIT])
               begin
                  // integrity check of the staged key, battery store only
                  status_next[`TDR_ST_CRC_OK] = (crc_run_reg == crc_exp_reg) & ~fsel_sync_reg[1];
                  if (crc_run_reg == crc_exp_reg && !fsel_sync_reg[1])
                  begin
                     key_next = stage_reg;
                     status_next[`TDR_ST_POR_NEEDED] = 1'b1;
                  end
                  crc_run_next = `TDR_CRC_INIT;
               end
            end
            default:
            begin
               // staging window for a new key, words written in order
               if (a >= `TDR_OFF_KEY_BASE && a < `TDR_OFF_CLK_COUNT)
               begin
                  stage_next[a[4:2]] = wb_dat_i;
                  crc_run_next       = crc_step(crc_run_reg, wb_dat_i);
               end
            end
         endcase
      end
      // tamper event applies every selected penalty, together if both set
      if (tamper)
      begin
         do_rep  = do_rep  | rsp_reg[`TDR_RSP_REPROG];
         do_wipe = do_wipe | rsp_reg[`TDR_RSP_KEY_WIPE];
      end
      if (do_wipe)
      begin
         for (int k = 0; k < KEY_WORDS; k++)
         begin
            key_next[k] = 32'h00000000;
         end
      end
      key_zero = 1'b1;
      for (int k = 0; k < KEY_WORDS; k++)
      begin
         key_zero = key_zero & (key_next[k] == 32'h00000000);
      end
      status_next[`TDR_ST_KEY_ZERO] = key_zero;
      // old encrypted image is unusable once the battery key is gone
      status_next[`TDR_ST_BOOT_OK]  = fsel_sync_reg[1] | ~key_zero;
      // penalty sequencer: hold the program-pin equivalent
      case (seq_reg)
         tdr_pkg::TDR_IDLE:
         begin
            if (do_rep)
            begin
               seq_next      = tdr_pkg::TDR_WIPE;
               wipe_cnt_next = 8'(`TDR_WIPE_CYCLES - 1);
            end
         end
         tdr_pkg::TDR_WIPE:
         begin
            if (wipe_cnt_reg == 8'h00)
            begin
               seq_next = tdr_pkg::TDR_IDLE;
            end
            else
            begin
               wipe_cnt_next = wipe_cnt_reg - 8'h01;
            end
         end
         default: seq_next = tdr_pkg::TDR_IDLE;
      endcase
      status_next[`TDR_ST_WIPING] = (seq_next == tdr_pkg::TDR_WIPE);
      // image load gate
      lacc_next = 1'b0;
      lref_next = 1'b0;
      if (load_req_i)
      begin
         if ((fsel_sync_reg[1] && enco_sync_reg[1] && !load_encrypted_i) ||
             status_reg[`TDR_ST_POR_NEEDED] || seq_reg == tdr_pkg::TDR_WIPE ||
             (load_encrypted_i && !status_reg[`TDR_ST_BOOT_OK]))
         begin
            lref_next = 1'b1;
         end
         else
         begin
            lacc_next = 1'b1;
         end
      end
      status_next[`TDR_ST_LOAD_REFUSED] = status_reg[`TDR_ST_LOAD_REFUSED] | lref_next;
      // outputs
      irq_next    = temp_al | vrail_al | clk_bad;
      shut_next   = shut_reg | (temp_al & ctrl_reg[`TDR_CTRL_OT_SHUT_EN]);
      reprog_next = (seq_next == tdr_pkg::TDR_WIPE);
      wipe_next   = do_wipe;
      // bus read data and ack
      case (a)
         `TDR_OFF_CTRL:      rd = {28'h0000000, ctrl_reg};
         `TDR_OFF_TEMP_LIM:  rd = temp_lim_reg;
         `TDR_OFF_VRAIL_LIM: rd = vrail_lim_reg;
         `TDR_OFF_CLK_LIM:   rd = clk_lim_reg;
         `TDR_OFF_STATUS:    rd = {22'h000000, status_reg};
         `TDR_OFF_RESPONSE:  rd = {30'h00000000, rsp_reg};
         `TDR_OFF_KEY_CRC:   rd = crc_exp_reg;
         `TDR_OFF_CLK_COUNT: rd = 32'(last_cnt_reg);
         default:            rd = 32'h00000000;
      endcase
      ack_next = req & ~ack_reg;
      dat_next = (req & ~ack_reg & ~wb_we_i) ? rd : 32'h00000000;
   end

   // ------------------------------------------------------------------
   // registers, all on the oscillator clock
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg      <= `TDR_CTRL_RESET;
         temp_lim_reg  <= 32'hFFFF0000;
         vrail_lim_reg <= 32'hFFFF0000;
         clk_lim_reg   <= 32'hFFFF0000;
         rsp_reg       <= '0;
         crc_exp_reg   <= 32'h00000000;
         crc_run_reg   <= `TDR_CRC_INIT;
         for (int k = 0; k < KEY_WORDS; k++)
         begin
            stage_reg[k] <= 32'h00000000;
            key_reg[k]   <= 32'h00000000;
         end
         status_reg    <= 10'h000;
         win_reg       <= '0;
         edge_reg      <= '0;
         last_cnt_reg  <= '0;
         wipe_cnt_reg  <= 8'h00;
         seq_reg       <= tdr_pkg::TDR_IDLE;
         dat_reg       <= 32'h00000000;
         ack_reg       <= 1'b0;
         irq_reg       <= 1'b0;
         shut_reg      <= 1'b0;
         reprog_reg    <= 1'b0;
         wipe_reg      <= 1'b0;
         lacc_reg      <= 1'b0;
         lref_reg      <= 1'b0;
      end
      else
      begin
         ctrl_reg      <= ctrl_next;
         temp_lim_reg  <= temp_lim_next;
         vrail_lim_reg <= vrail_lim_next;
         clk_lim_reg   <= clk_lim_next;
         rsp_reg       <= rsp_next;
         crc_exp_reg   <= crc_exp_next;
         crc_run_reg   <= crc_run_next;
         stage_reg     <= stage_next;
         key_reg       <= key_next;
         status_reg    <= status_next;
         win_reg       <= win_next;
         edge_reg      <= edge_next;
         last_cnt_reg  <= last_cnt_next;
         wipe_cnt_reg  <= wipe_cnt_next;
         seq_reg       <= seq_next;
         dat_reg       <= dat_next;
         ack_reg       <= ack_next;
         irq_reg       <= irq_next;
         shut_reg      <= shut_next;
         reprog_reg    <= reprog_next;
         wipe_reg      <= wipe_next;
         lacc_reg      <= lacc_next;
         lref_reg      <= lref_next;
      end
   end

   assign wb_dat_o      = dat_reg;
   assign wb_ack_o      = ack_reg;
   assign alarm_irq_o   = irq_reg;
   assign shutdown_o    = shut_reg;
   assign reprogram_o   = reprog_reg;
   assign key_wipe_o    = wipe_reg;
   assign load_accept_o = lacc_reg;
   assign load_refuse_o = lref_reg;

endmodule : tdr_top
`default_nettype wire

//--- tdr_defs.svh
// tdr_defs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the tamper block sources
`ifndef TDR_DEFS_SVH
`define TDR_DEFS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define TDR_OFF_CTRL        8'h00
`define TDR_OFF_TEMP_LIM    8'h04
`define TDR_OFF_VRAIL_LIM   8'h08
`define TDR_OFF_CLK_LIM     8'h0C
`define TDR_OFF_STATUS      8'h10
`define TDR_OFF_RESPONSE    8'h14
`define TDR_OFF_COMMAND     8'h18
`define TDR_OFF_KEY_CRC     8'h1C
`define TDR_OFF_KEY_BASE    8'h20
`define TDR_OFF_CLK_COUNT   8'h40

// ------------------------------------------------------------------
// control bits
// ------------------------------------------------------------------
`define TDR_CTRL_TEMP_EN    0
`define TDR_CTRL_VRAIL_EN   1
`define TDR_CTRL_CLKMON_EN  2
`define TDR_CTRL_OT_SHUT_EN 3

// ------------------------------------------------------------------
// status bits
// ------------------------------------------------------------------
`define TDR_ST_TEMP_ALARM   0
`define TDR_ST_VRAIL_ALARM  1
`define TDR_ST_CLK_FAULT    2
`define TDR_ST_VREF_INT     3
`define TDR_ST_KEY_ZERO     4
`define TDR_ST_CRC_OK       5
`define TDR_ST_WIPING       6
`define TDR_ST_BOOT_OK      7
`define TDR_ST_LOAD_REFUSED 8
`define TDR_ST_POR_NEEDED   9

// ------------------------------------------------------------------
// response select bits (set only) and command bits
// ------------------------------------------------------------------
`define TDR_RSP_REPROG      0
`define TDR_RSP_KEY_WIPE    1
`define TDR_RSP_W           2
`define TDR_CMD_REPROG      0
`define TDR_CMD_KEY_WIPE    1
`define TDR_CMD_KEY_COMMIT  2

// ------------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------------
`define TDR_CTRL_RESET      4'h0
`define TDR_CLK_MHZ         50
`define TDR_WIPE_TIME_NS    200
`define TDR_WIPE_CYCLES     ((`TDR_WIPE_TIME_NS * `TDR_CLK_MHZ + 999) / 1000)
`define TDR_CRC_POLY        32'h04C11DB7
`define TDR_CRC_INIT        32'hFFFFFFFF

`endif

//--- tdr_pkg.sv
// tdr_pkg.sv: types shared by the tamper block
// assumes: compiled before tdr_top.sv
package tdr_pkg;
   // penalty sequencer states
   typedef enum logic [0:0] {TDR_IDLE, TDR_WIPE} tdr_seq_type;
endpackage : tdr_pkg

//--- tdr_monitor.sv
// tdr_monitor.sv: port checks for the tamper block
// assumes: bound to tdr_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module tdr_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        alarm_irq_o,
   input wire logic        shutdown_o,
   input wire logic        reprogram_o,
   input wire logic        key_wipe_o,
   input wire logic        load_req_i,
   input wire logic        load_accept_o,
   input wire logic        load_refuse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ten-cycle clearing pulse
   sequence wipe_run;
      reprogram_o[*8] ##1 reprogram_o[*2] ##1 !reprogram_o;
   endsequence
   ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not idle");
   shut_sticky_a: assert property (shutdown_o |=> shutdown_o) else $error("shutdown dropped");
   shut_irq_a: assert property ($rose(shutdown_o) |-> alarm_irq_o) else $error("shutdown without irq");
   wipe_len_a: assert property ($rose(reprogram_o) |-> wipe_run) else $error("clear length wrong");
   key_pulse_a: assert property (key_wipe_o |=> !key_wipe_o) else $error("key wipe not a pulse");
   load_answer_a: assert property (load_req_i |=> load_accept_o != load_refuse_o) else $error("load answer");
   load_quiet_a: assert property (!load_req_i |=> !(load_accept_o || load_refuse_o)) else $error("stray load");
   wipe_refuse_a: assert property (reprogram_o && load_req_i |=> load_refuse_o) else $error("load in clear");
endmodule : tdr_monitor
`default_nettype wire

//--- tdr_clk_src.sv
// tdr_clk_src.sv: user clock source, stops and holds when run_i is low
// assumes: 40 ns half period, never on a rising clk_i edge, slow enough to sample cleanly
`timescale 1ns/1ps
`default_nettype none
module tdr_clk_src (
   input wire logic run_i,
   output logic     clk_o
);
   initial clk_o = 1'h0;
   always
   begin
      #40;
      if (run_i) clk_o = ~clk_o;
   end
endmodule : tdr_clk_src
`default_nettype wire

//--- tdr_top_tb.sv
// tdr_top_tb.sv: self-checking bench for tdr_top
// assumes: monitor and clock source compiled first
`timescale 1ns/1ps
`default_nettype none
module tdr_top_tb;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run, vref, fsel, enc_only;
   logic user_clk_i, load_req_i, load_encrypted_i, alarm_irq_o, shutdown_o;
   logic reprogram_o, key_wipe_o, load_accept_o, load_refuse_o, seen;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, q, crc;
   logic [9:0]  temp, vrail;
   int          mismatches, n_compared, cyc_n;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tdr_row_type;
   tdr_row_type rows [4] = '{'{8'h00, 32'h5, 32'h5}, '{8'h04, 32'h01230010, 32'h01230010},
      '{8'h0C, 32'h00200008, 32'h00200008}, '{8'h44, 32'hFFFFFFFF, 32'h0}};
   tdr_top #(.WINDOW_CYCLES(64)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .temp_meas_i(temp),
      .vrail_meas_i(vrail), .user_clk_i(user_clk_i), .vref_int_sel_i(vref), .fuse_key_sel_i(fsel),
      .enc_only_fuse_i(enc_only), .load_req_i(load_req_i), .load_encrypted_i(load_encrypted_i),
      .alarm_irq_o(alarm_irq_o), .shutdown_o(shutdown_o), .reprogram_o(reprogram_o),
      .key_wipe_o(key_wipe_o), .load_accept_o(load_accept_o), .load_refuse_o(load_refuse_o));
   tdr_clk_src src (.run_i(run), .clk_o(user_clk_i));
   initial
   begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end
   // hang guard
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 5000)
      begin
         mismatches++;
         conclude();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // reference crc-32, msb first, no reflection
   function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d);
      for (int i = 31; i >= 0; i--)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C11DB7 : 32'h00000000);
      return c;
   endfunction : crc_ref
   // classic single wishbone cycle
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask : bus
   // one load request, answer {accept, refuse}
   task ld(input logic enc, input logic [1:0] e);
      @(posedge clk_i);
      {load_req_i, load_encrypted_i} <= {1'h1, enc};
      @(posedge clk_i);
      load_req_i <= 1'h0;
      @(posedge clk_i);
      chk({30'h0, load_accept_o, load_refuse_o}, {30'h0, e});
   endtask : ld
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'h1, 43'h0};
      {temp, vrail, vref, fsel, enc_only, load_req_i, load_encrypted_i, run} = {10'h80, 10'h80, 6'h21};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      bus(8'h10, 1'h0, 32'h0);
      chk(q & 32'h3FF, 32'h18);
      bus(8'h04, 1'h0, 32'h0);
      chk(q, 32'hFFFF0000);
      foreach (rows[i])
      begin
         bus(rows[i].a, 1'h1, rows[i].d);
         bus(rows[i].a, 1'h0, 32'h0);
         chk(q, rows[i].e);
      end
      ld(1'h0, 2'h2);
      {fsel, enc_only} <= 2'h3;
      repeat (4) @(posedge clk_i);
      ld(1'h0, 2'h1);
      {fsel, enc_only} <= 2'h0;
      bus(8'h14, 1'h1, 32'h3);
      bus(8'h14, 1'h1, 32'h0);
      bus(8'h14, 1'h0, 32'h0);
      chk(q, 32'h3);
      $display("registers and load done");
      bus(8'h04, 1'h1, 32'h01000010);
      bus(8'h00, 1'h1, 32'h9);
      foreach (rows[i]) if (i < 3)
      begin
         temp <= i == 1 ? 10'h80 : i == 0 ? 10'h200 : 10'h5;
         repeat (3) @(posedge clk_i);
         chk({alarm_irq_o, shutdown_o}, i == 1 ? 2'h1 : 2'h3);
      end
      temp <= 10'h80;
      bus(8'h00, 1'h1, 32'h4);
      repeat (130) @(posedge clk_i);
      bus(8'h40, 1'h0, 32'h0);
      // 64 cycles of 20 ns against an 80 ns user clock
      chk(q, 32'h10);
      bus(8'h10, 1'h0, 32'h0);
      chk(q & 32'h4, 32'h0);
      $display("alarms done");
      run <= 1'h0;
      seen = 1'h0;
      repeat (200) if (!seen) @(posedge clk_i) seen = reprogram_o;
      chk({31'h0, seen}, 32'h1);
      ld(1'h0, 2'h1);
      repeat (10) @(posedge clk_i);
      ld(1'h1, 2'h1);
      bus(8'h10, 1'h0, 32'h0);
      chk(q & 32'h14, 32'h14);
      $display("penalty done");
      // mid-run reset clears selections; then stage, commit and wipe a key
      rst_i <= 1'h1;
      run <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      bus(8'h14, 1'h0, 32'h0);
      chk(q, 32'h0);
      crc = 32'hFFFFFFFF;
      for (int k = 0; k < 8; k++)
      begin
         bus(8'h20 + 8'(4 * k), 1'h1, 32'h1000 + k);
         crc = crc_ref(crc, 32'h1000 + k);
      end
      bus(8'h1C, 1'h1, crc);
      bus(8'h18, 1'h1, 32'h4);
      bus(8'h10, 1'h0, 32'h0);
      chk(q & 32'h2B0, 32'h2A0);
      ld(1'h0, 2'h1);
      bus(8'h18, 1'h1, 32'h2);
      bus(8'h10, 1'h0, 32'h0);
      chk(q & 32'h90, 32'h10);
      $display("key and reset done");
      conclude();
   end
endmodule : tdr_top_tb
bind tdr_top tdr_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .alarm_irq_o(alarm_irq_o), .shutdown_o(shutdown_o),
   .reprogram_o(reprogram_o), .key_wipe_o(key_wipe_o), .load_req_i(load_req_i),
   .load_accept_o(load_accept_o), .load_refuse_o(load_refuse_o));
`default_nettype wire
